//--- shared/spck_pkg.sv
// Purpose: Constants for the clock-stop serial port (SPI mode)
// Assumes: 32-bit APB, 100 MHz pclk
// Notes:   One peripheral period P equals one pclk cycle
package spck_pkg;
  localparam int PCLK_NS = 10;
  localparam int P_NS    = 10;
  localparam int P_CYC   = P_NS / PCLK_NS;

  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DIV    = 8'h04;
  localparam logic [7:0] OFS_TXDATA = 8'h08;
  localparam logic [7:0] OFS_RXDATA = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  localparam int CB_EN   = 0;
  localparam int CB_MODE = 1;
  localparam int CB_CKP  = 3;
  localparam int CB_RSP  = 4;
  localparam int CB_TSP  = 5;
  localparam int CB_TCD  = 6;
  localparam int CB_TSD  = 7;
  localparam int CB_RCD  = 8;
  localparam int CB_RSD  = 9;
  localparam int CB_SRC  = 10;
  localparam int CTRL_W  = 11;

  localparam logic [10:0] CTRL_RST = 11'h000;
  localparam logic [7:0]  DIV_RST  = 8'h01;
  localparam logic [7:0]  DIV_SLV  = 8'h01;

  localparam logic [1:0] MODE_HALF = 2'h2;
  localparam logic [1:0] MODE_FULL = 2'h3;

  localparam int SB_BUSY = 0;
  localparam int SB_RXF  = 1;
  localparam int SB_OVR  = 2;
  localparam int SB_TXE  = 3;
  localparam int SB_SLOK = 4;

  localparam int SY_DI = 0;
  localparam int SY_RS = 1;
  localparam int SY_TS = 2;
  localparam int SY_CK = 3;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'h0,
    ST_LEAD  = 3'h1,
    ST_SHIFT = 3'h2,
    ST_TAIL  = 3'h3,
    ST_SLAVE = 3'h4
  } spck_state_e;
endpackage : spck_pkg

//--- hw/spck_top.sv
// Purpose: Clock-stop SPI serial port, master or slave, APB registers
// Assumes: P is one pclk cycle; pins pass two flops before use
// Notes:   Transmit words pass an 8-deep FIFO written over APB
// Operation
// R1 - Slave runs only with source select set and divider equal one
// R2 - Timing unit P is one peripheral clock cycle
// R3 - Master clock period is one plus divider, times P; divider zero gives 2 P instead
// R4 - Low phase is half period if divider odd/zero, else divider/2 P
// R5 - High phase is half period if odd/zero, else divider/2 plus one P
// R6 - Master select output inverted when sync polarity bits set
// R7 - Slave inverts active-low select inputs before internal use
// R8 - Master: transmit clock and sync driven, receive ones inputs
// R9 - Slave: all four clock and sync directions are inputs
// R10 - Select asserted before first clock edge; transfer follows it
// R11 - Mode 10b polarity 1 captures input on rising clock edge
// R12 - Output data updates after falling edges in both shown modes
// R13 - Mode 11b master: first rising edge one period after select
// R14 - Mode 10b master: first falling edge one high phase after select
// R15 - Mode 11b: first bit one high phase after select as master
// R16 - Mode 11b: output released at last falling clock edge
// R17 - Mode 10b master: output released one high phase after last edge
// R18 - External master asserts select before first falling edge
// R19 - Serial clock idles while select is deasserted
//
// Added by the designer: the placing of the registers and register access over APB.
module spck_fifo
  import spck_pkg::*;
#(
  parameter int W = 8,
  parameter int D = 8
)
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0]         wp;
    logic [AW:0]         rp;
  } spck_fifo_s;
  spck_fifo_s f_reg;
  spck_fifo_s f_next;
  logic       full;

  assign full = (f_reg.wp[AW] != f_reg.rp[AW])
             && (f_reg.wp[AW-1:0] == f_reg.rp[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = f_reg.wp != f_reg.rp;
  assign out_data  = f_reg.mem[f_reg.rp[AW-1:0]];

  always_comb
  begin
    f_next = f_reg;
    if (in_valid && !full)
    begin
      f_next.mem[f_reg.wp[AW-1:0]] = in_data;
      f_next.wp = f_reg.wp + 1'b1;
    end
    if (out_ready && out_valid)
      f_next.rp = f_reg.rp + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      f_reg <= '0;
    else
      f_reg <= f_next;
  end
endmodule : spck_fifo

module spck_top
  import spck_pkg::*;
#(
  parameter int W     = 8,
  parameter int DEPTH = 8
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_clock_pin_in,
  output logic             serial_clock_pin_out,
  output logic             serial_clock_pin_oe,
  input  wire logic        select_pin_tx_in,
  output logic             select_pin_tx_out,
  output logic             select_pin_tx_oe,
  input  wire logic        select_pin_rx_in,
  output logic             serial_out_pin_out,
  output logic             serial_out_pin_oe,
  input  wire logic        serial_in_pin_in
);
  localparam int EW = $clog2(2 * W + 1);
  localparam logic [EW-1:0] LAST = EW'(2 * W);

  typedef struct packed {
    spck_state_e       st;
    logic [CTRL_W-1:0] ctrl;
    logic [7:0]        div;
    logic [8:0]        cnt;
    logic [EW-1:0]     ec;
    logic [W-1:0]      sh;
    logic [W-1:0]      rx;
    logic [W-1:0]      rxd;
    logic              sclk;
    logic              sel;
    logic              oe;
    logic              rxf;
    logic              ovr;
    logic [3:0]        y1;
    logic [3:0]        y2;
    logic              ck3;
    logic [31:0]       rdata;
  } spck_top_s;

  localparam spck_top_s RST = '{st: ST_IDLE, ctrl: CTRL_RST,
                                div: DIV_RST, default: '0};

  spck_top_s     s_reg;
  spck_top_s     s_next;
  logic          pol;
  logic          m11;
  logic          mst;
  logic          slv;
  logic          act;
  logic          sel_act;
  logic          f_valid;
  logic          f_in_ready;
  logic [W-1:0]  f_data;
  logic          tx_take;
  logic          tx_wr;
  logic          acc;
  logic          hit;
  logic          lead_e;
  logic          trail_e;
  logic          done;
  logic [8:0]    ph_lo;
  logic [8:0]    ph_hi;
  logic [8:0]    ph_cnt;

  // Phase length in P; divider zero cannot split one P, so 1 each
  function automatic logic [8:0] ph_len(input logic [7:0] d, // R2
                                        input logic       hi);
    if (d == 8'h00)
      ph_len = 9'h001;
    else if (d[0])
      ph_len = ({1'b0, d} + 9'h001) >> 1;
    else
      ph_len = {2'b00, d[7:1]} + {8'h00, hi};
  endfunction : ph_len

  assign pol   = s_reg.ctrl[CB_CKP];
  assign m11   = s_reg.ctrl[CB_MODE+:2] == MODE_FULL;
  assign act   = s_reg.ctrl[CB_EN] && s_reg.ctrl[CB_MODE+1];
  assign ph_lo = ph_len(s_reg.div, 1'b0); // R4
  assign ph_hi = ph_len(s_reg.div, 1'b1); // R5
  assign mst   = s_reg.ctrl[CB_TCD] && s_reg.ctrl[CB_TSD]
              && !s_reg.ctrl[CB_RCD] && !s_reg.ctrl[CB_RSD]; // R8
  assign slv   = !s_reg.ctrl[CB_TCD] && !s_reg.ctrl[CB_TSD]
              && !s_reg.ctrl[CB_RCD] && !s_reg.ctrl[CB_RSD] // R9
              && s_reg.ctrl[CB_SRC] && s_reg.div == DIV_SLV; // R1
  assign sel_act = (s_reg.y2[SY_TS] ^ s_reg.ctrl[CB_TSP]) // R7
                && (s_reg.y2[SY_RS] ^ s_reg.ctrl[CB_RSP]); // R7

  assign acc     = psel && penable;
  assign hit     = paddr == OFS_CTRL || paddr == OFS_DIV
                || paddr == OFS_TXDATA || paddr == OFS_RXDATA
                || paddr == OFS_STATUS;
  assign tx_wr   = acc && pwrite && paddr == OFS_TXDATA;
  // Full FIFO holds the bus instead of dropping the word
  assign pready  = !(tx_wr && !f_in_ready);
  assign pslverr = acc && !hit;
  assign prdata  = s_reg.rdata;

  assign serial_clock_pin_out = s_reg.sclk;
  assign serial_clock_pin_oe  = s_reg.ctrl[CB_TCD]; // R8 R9
  assign select_pin_tx_out    = s_reg.sel ^ s_reg.ctrl[CB_TSP]; // R6
  assign select_pin_tx_oe     = s_reg.ctrl[CB_TSD]; // R8 R9
  assign serial_out_pin_out   = s_reg.sh[W-1];
  assign serial_out_pin_oe    = s_reg.oe;

  spck_fifo #(.W(W), .D(DEPTH)) u_txq
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (tx_wr),
    .in_ready  (f_in_ready),
    .in_data   (pwdata[W-1:0]),
    .out_valid (f_valid),
    .out_ready (tx_take),
    .out_data  (f_data)
  );

  always_comb
  begin
    s_next  = s_reg;
    tx_take = 1'b0;
    lead_e  = 1'b0;
    trail_e = 1'b0;
    done    = 1'b0;
    s_next.y1  = {serial_clock_pin_in, select_pin_tx_in,
                  select_pin_rx_in, serial_in_pin_in};
    s_next.y2  = s_reg.y1;
    s_next.ck3 = s_reg.y2[SY_CK];

    if (psel && !penable)
    begin
      unique case (paddr)
        OFS_CTRL:   s_next.rdata = {21'h000000, s_reg.ctrl};
        OFS_DIV:    s_next.rdata = {24'h000000, s_reg.div};
        OFS_RXDATA: s_next.rdata = 32'(s_reg.rxd);
        OFS_STATUS: s_next.rdata = {27'h0000000, slv, !f_valid,
                                    s_reg.ovr, s_reg.rxf,
                                    s_reg.st != ST_IDLE};
        default:    s_next.rdata = 32'h00000000;
      endcase
    end
    if (acc && pready && hit)
    begin
      if (pwrite && paddr == OFS_CTRL)
        s_next.ctrl = pwdata[CTRL_W-1:0];
      if (pwrite && paddr == OFS_DIV)
        s_next.div = pwdata[7:0];
      if (pwrite && paddr == OFS_STATUS && pwdata[SB_OVR])
        s_next.ovr = 1'b0;
      if (!pwrite && paddr == OFS_RXDATA)
        s_next.rxf = 1'b0;
    end

    unique case (s_reg.st)
      ST_IDLE:
      begin
        s_next.sclk = pol; // R19
        s_next.ec   = '0;
        if (act && mst && f_valid)
        begin
          tx_take     = 1'b1;
          s_next.sh   = f_data;
          s_next.sel  = 1'b1; // R10
          s_next.oe   = !m11;
          s_next.cnt  = m11 ? ph_lo + ph_hi - 9'h001 // R3 R13
                            : ph_len(s_reg.div, pol) - 9'h001; // R14
          s_next.st   = ST_LEAD;
        end
        else if (act && slv && sel_act)
        begin
          tx_take     = f_valid;
          s_next.sh   = f_valid ? f_data : '0;
          s_next.oe   = 1'b1; // R15
          s_next.st   = ST_SLAVE;
        end
      end
      ST_LEAD:
      begin
        if (m11 && s_reg.cnt <= ph_lo)
          s_next.oe = 1'b1; // R15
        if (s_reg.cnt == 9'h000)
        begin
          s_next.sclk = !s_reg.sclk; // R10
          lead_e      = 1'b1;
          s_next.cnt  = ph_len(s_reg.div, !s_reg.sclk) - 9'h001;
          s_next.st   = ST_SHIFT;
        end
        else
          s_next.cnt = s_reg.cnt - 9'h001;
      end
      ST_SHIFT:
      begin
        if (s_reg.cnt == 9'h000)
        begin
          s_next.sclk = !s_reg.sclk;
          lead_e      = s_reg.sclk == pol;
          trail_e     = s_reg.sclk != pol;
          s_next.cnt  = ph_len(s_reg.div, !s_reg.sclk) - 9'h001; // R3
        end
        else
          s_next.cnt = s_reg.cnt - 9'h001;
      end
      ST_TAIL:
      begin
        if (s_reg.cnt == 9'h000)
        begin
          s_next.oe  = 1'b0; // R17
          s_next.sel = 1'b0; // R19
          s_next.st  = ST_IDLE;
        end
        else
          s_next.cnt = s_reg.cnt - 9'h001;
      end
      ST_SLAVE:
      begin
        lead_e  = s_reg.y2[SY_CK] != s_reg.ck3 && s_reg.y2[SY_CK] != pol;
        trail_e = s_reg.y2[SY_CK] != s_reg.ck3 && s_reg.y2[SY_CK] == pol;
        if (!sel_act)
        begin
          s_next.oe = 1'b0;
          s_next.st = ST_IDLE;
        end
      end
      default:
        s_next.st = ST_IDLE;
    endcase

    if (lead_e || trail_e)
    begin
      s_next.ec = s_reg.ec + 1'b1;
      if (lead_e == m11)
        s_next.rx = {s_reg.rx[W-2:0], s_reg.y2[SY_DI]}; // R11
      else if (s_reg.ec != '0 && !(m11 && s_next.ec == LAST))
        s_next.sh = {s_reg.sh[W-2:0], 1'b0}; // R12
      if (m11 && trail_e && s_next.ec == LAST)
        s_next.oe = 1'b0; // R16
      done = s_next.ec == LAST;
    end
    if (done && s_reg.st == ST_SHIFT)
    begin
      s_next.st  = ST_TAIL;
      s_next.cnt = ph_len(s_reg.div, pol) - 9'h001; // R17
    end
    if (done)
    begin
      // Set beats a same-cycle read clear
      s_next.ovr = s_next.ovr || (s_reg.rxf && s_next.rxf);
      s_next.rxf = 1'b1;
      s_next.rxd = s_next.rx;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_reg <= RST;
    else
      s_reg <= s_next;
  end

  // Cycles since the last clock toggle or select rise
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ph_cnt <= 9'h000;
    else if (s_next.sclk != s_reg.sclk || (s_next.sel && !s_reg.sel))
      ph_cnt <= 9'h000;
    else
      ph_cnt <= ph_cnt + 9'h001;
  end

  a_slave_rate_cfg: assert property (@(posedge pclk) disable iff (!presetn) // R1
    $rose(s_reg.st == ST_SLAVE) |-> s_reg.ctrl[CB_SRC] && s_reg.div == DIV_SLV)
    else $error("slave started with wrong rate setting");
  a_phase_len: assert property (@(posedge pclk) disable iff (!presetn) // R3
    s_reg.st == ST_SHIFT && s_next.sclk != s_reg.sclk
    |-> ph_cnt == ph_len(s_reg.div, s_reg.sclk) - 9'h001)
    else $error("serial clock phase length wrong");
  a_sel_active_low: assert property (@(posedge pclk) disable iff (!presetn) // R6
    s_reg.st == ST_SHIFT && s_reg.ctrl[CB_TSP] |-> !select_pin_tx_out)
    else $error("select not driven low during transfer");
  a_slave_release: assert property (@(posedge pclk) disable iff (!presetn) // R7
    s_reg.st == ST_SLAVE && !sel_act |=> !s_reg.oe)
    else $error("slave kept data out after deselect");
  a_master_dirs: assert property (@(posedge pclk) disable iff (!presetn) // R8
    $rose(s_reg.st == ST_LEAD) |-> serial_clock_pin_oe && select_pin_tx_oe)
    else $error("master started without driving clock and select");
  a_first_edge: assert property (@(posedge pclk) disable iff (!presetn) // R13
    s_reg.st == ST_LEAD && s_next.sclk != s_reg.sclk && m11
    |-> s_reg.sel && ph_cnt == ph_lo + ph_hi - 9'h001)
    else $error("first clock edge not one period after select");
  a_first_half: assert property (@(posedge pclk) disable iff (!presetn) // R14
    s_reg.st == ST_LEAD && s_next.sclk != s_reg.sclk && !m11
    |-> ph_cnt == ph_len(s_reg.div, pol) - 9'h001)
    else $error("first clock edge not one phase after select");
  a_first_bit: assert property (@(posedge pclk) disable iff (!presetn) // R15
    $rose(s_reg.oe) && $past(s_reg.st) == ST_LEAD |-> ph_cnt == ph_hi)
    else $error("first bit not one high phase after select");
  a_out_edge: assert property (@(posedge pclk) disable iff (!presetn) // R12
    $past(s_reg.st) == ST_SHIFT && $changed(s_reg.sh)
    |-> $changed(s_reg.sclk) && ((s_reg.sclk == pol) == m11))
    else $error("data changed on wrong clock edge");
  a_release_11: assert property (@(posedge pclk) disable iff (!presetn) // R16
    $fell(s_reg.oe) && $past(s_reg.st) == ST_SHIFT
    |-> m11 && $changed(s_reg.sclk) && s_reg.sclk == pol)
    else $error("output not released at last falling edge");
  a_release_10: assert property (@(posedge pclk) disable iff (!presetn) // R17
    $fell(s_reg.oe) && $past(s_reg.st) == ST_TAIL && !m11
    |-> ph_cnt == ph_len(s_reg.div, pol))
    else $error("output not released one phase after last edge");
  a_clock_idle: assert property (@(posedge pclk) disable iff (!presetn) // R19
    s_reg.st == ST_IDLE && $past(s_reg.st) == ST_IDLE
    && $stable(s_reg.ctrl) |-> s_reg.sclk == pol)
    else $error("serial clock moved while idle");
endmodule : spck_top

//--- verif/spck_ext_slave.sv
// Purpose: External SPI slave device facing the port in master role
// Assumes: Select active low; data changes on falling clock edges
// Notes:   A released data line shows the inverse of its last bit
module spck_ext_slave
#(
  parameter int W = 8
)
(
  input  wire logic         sclk,
  input  wire logic         sel_n,
  input  wire logic         sdi,
  input  wire logic [W-1:0] tx_word,
  output logic              sdo,
  output logic      [W-1:0] rx_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [W-1:0] sh_reg;
  logic         drv;
  int           n;

  initial
  begin
    sh_reg = '0;
    rx_word = '0;
    drv = 1'b0;
    n = 0;
  end

  always @(negedge sel_n)
  begin
    sh_reg = tx_word;
    n = 0;
    drv = 1'b1;
  end

  always @(posedge sel_n)
    drv = 1'b0;

  // Clock is ignored unless selected first
  always @(posedge sclk)
    if (!sel_n)
    begin
      rx_word = {rx_word[W-2:0], sdi};
      n++;
    end

  // No shift before a sample: mode 10b opens with a falling edge
  always @(negedge sclk)
    if (!sel_n && n > 0 && n < W)
      sh_reg = {sh_reg[W-2:0], 1'b0};

  assign sdo = drv ? sh_reg[W-1] : ~sh_reg[W-1];
endmodule : spck_ext_slave

//--- verif/tb.sv
// Purpose: Self-checking bench for the clock-stop serial port
// Assumes: Select is active low, both sync polarity bits set
// Notes:   Pin timing is measured in pclk cycles by a monitor
module tb
  import spck_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rq;
  logic        sck_o, sck_oe, sel_o, sel_oe, sdo_o, sdo_oe, miso, lerr;
  logic        ext_sck, ext_sel, ext_din, slv, sck_q, sel_q, oe_q;
  logic        sck_w, sel_w, sdo_w, din_w;
  logic [7:0]  m_tx, m_rx;
  logic [7:0]  rxq[$];
  int          cyc, ne, t_sel, t_selr, t_oe, t_oef, lwait;
  int          et[32];
  int          mismatches, n_tests;

  spck_top dut
  (
    .pclk                 (pclk),
    .presetn              (presetn),
    .paddr                (paddr),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .serial_clock_pin_in  (sck_w),
    .serial_clock_pin_out (sck_o),
    .serial_clock_pin_oe  (sck_oe),
    .select_pin_tx_in     (sel_w),
    .select_pin_tx_out    (sel_o),
    .select_pin_tx_oe     (sel_oe),
    .select_pin_rx_in     (sel_w),
    .serial_out_pin_out   (sdo_o),
    .serial_out_pin_oe    (sdo_oe),
    .serial_in_pin_in     (din_w)
  );

  spck_ext_slave #(.W(8)) ext
  (
    .sclk    (sck_w),
    .sel_n   (sel_w),
    .sdi     (sdo_w),
    .tx_word (m_tx),
    .sdo     (miso),
    .rx_word (m_rx)
  );

  assign sck_w = sck_oe ? sck_o : ext_sck;
  assign sel_w = sel_oe ? sel_o : ext_sel;
  // Released line shows the inverse so a late sample is caught
  assign sdo_w = sdo_oe ? sdo_o : ~sdo_o;
  assign din_w = slv ? ext_din : miso;

  always #5 pclk = ~pclk;

  always @(posedge pclk)
  begin
    cyc++;
    if (sck_w !== sck_q && ne < 32)
    begin
      et[ne] = cyc;
      ne++;
    end
    if (sel_q === 1'b1 && sel_w === 1'b0)
      t_sel = cyc;
    if (sel_q === 1'b0 && sel_w === 1'b1)
    begin
      t_selr = cyc;
      rxq.push_back(m_rx);
    end
    if (oe_q === 1'b0 && sdo_oe === 1'b1)
      t_oe = cyc;
    if (oe_q === 1'b1 && sdo_oe === 1'b0)
      t_oef = cyc;
    sck_q = sck_w;
    sel_q = sel_w;
    oe_q = sdo_oe;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task automatic bust();
    mismatches++;
    $display("BAD wait limit exp done got stuck");
    close_out();
  endtask : bust

  task automatic chk(input string nm, input logic [31:0] e, s);
    n_tests++;
    if (s !== e)
    begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    lwait = 0;
    do
    begin
      @(posedge pclk);
      lwait++;
    end
    while (pready !== 1'b1 && lwait < 3000);
    if (pready !== 1'b1)
      bust();
    rq = prdata;
    lerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_fr(input int n);
    for (int k = 0; k < 5000 && rxq.size() < n; k++)
      @(posedge pclk);
    if (rxq.size() < n)
      bust();
    repeat (4) @(posedge pclk);
  endtask : wait_fr

  task automatic t_regs();
    apb(1'b0, OFS_CTRL, '0);
    chk("ctrl", 32'(CTRL_RST), rq);
    apb(1'b0, OFS_DIV, '0);
    chk("div", 32'(DIV_RST), rq);
    apb(1'b1, 8'h20, 32'h000000ff);
    chk("bad_wr", 1, lerr);
    apb(1'b0, 8'h20, '0);
    chk("bad_rd", 0, rq);
    $display("test regs done");
  endtask : t_regs

  task automatic mst(input logic [1:0] md, input logic pol,
                     input logic [7:0] dv, input logic [7:0] w);
    int l, h, a, b;
    l = (dv == 0) ? 1 : (dv[0] ? (dv + 1) / 2 : dv / 2);
    h = (dv == 0 || dv[0]) ? l : dv / 2 + 1;
    a = (md == MODE_FULL) ? h : l;
    b = (md == MODE_FULL) ? l : h;
    m_tx = ~w;
    apb(1'b1, OFS_CTRL, 32'h000000f1 | (32'(md) << CB_MODE)
        | (32'(pol) << CB_CKP));
    apb(1'b1, OFS_DIV, 32'(dv));
    chk("clk_oe", 1, sck_oe);
    chk("sel_oe", 1, sel_oe);
    chk("sel_idle", 1, sel_w);
    ne = 0;
    rxq = {};
    apb(1'b1, OFS_TXDATA, 32'(w));
    wait_fr(1);
    chk("first_edge", md == MODE_FULL ? l + h : h, et[0] - t_sel);
    chk("phase_1", a, et[1] - et[0]);
    chk("phase_2", b, et[2] - et[1]);
    chk("edges", 16, ne);
    chk("oe_on", md == MODE_FULL ? h : 0, t_oe - t_sel);
    chk("oe_off", md == MODE_FULL ? 0 : h, t_oef - et[15]);
    chk("sel_off", b, t_selr - et[15]);
    chk("tx_word", w, m_rx);
    apb(1'b0, OFS_RXDATA, '0);
    chk("rx_word", m_tx, rq[7:0]);
    $display("test master mode %0d div %0d done", md, dv);
  endtask : mst

  task automatic t_fifo();
    int tw;
    apb(1'b1, OFS_CTRL, 32'h000000f7);
    apb(1'b1, OFS_DIV, 32'h00000009);
    rxq = {};
    tw = 0;
    for (int i = 0; i < 10; i++)
    begin
      apb(1'b1, OFS_TXDATA, 32'h00000030 + 32'(i));
      tw += lwait;
    end
    chk("stalled", 1, tw > 10);
    wait_fr(10);
    for (int i = 0; i < 10; i++)
      chk("order", 32'h00000030 + 32'(i), rxq[i]);
    apb(1'b0, OFS_STATUS, '0);
    chk("status_ovr", 32'h0000000e, rq);
    apb(1'b1, OFS_STATUS, 32'h00000004);
    apb(1'b0, OFS_RXDATA, '0);
    chk("rx_last", m_tx, rq[7:0]);
    apb(1'b0, OFS_STATUS, '0);
    chk("status_clr", 32'h00000008, rq);
    $display("test fifo done");
  endtask : t_fifo

  task automatic t_slave(input logic [7:0] w, input logic [7:0] m);
    logic [7:0] got;
    slv = 1'b1;
    apb(1'b1, OFS_CTRL, 32'h00000437);
    apb(1'b1, OFS_DIV, 32'(DIV_SLV));
    apb(1'b1, OFS_TXDATA, 32'(w));
    apb(1'b0, OFS_STATUS, '0);
    chk("slave_ok", 1, rq[SB_SLOK]);
    chk("pins_in", 0, {sck_oe, sel_oe});
    ext_sel <= 1'b0;
    repeat (5) @(posedge pclk);
    for (int i = 7; i >= 0; i--)
    begin
      ext_din <= m[i];
      repeat (5) @(posedge pclk);
      got[i] = sdo_w;
      ext_sck <= 1'b1;
      repeat (5) @(posedge pclk);
      ext_sck <= 1'b0;
    end
    repeat (5) @(posedge pclk);
    ext_sel <= 1'b1;
    ext_din <= ~m[0];
    repeat (6) @(posedge pclk);
    chk("slave_tx", w, got);
    chk("slave_oe", 0, sdo_oe);
    apb(1'b0, OFS_RXDATA, '0);
    chk("slave_rx", m, rq[7:0]);
    slv = 1'b0;
    $display("test slave done");
  endtask : t_slave

  initial
  begin
    {pclk, presetn, psel, penable, pwrite} = '0;
    paddr = '0;
    pwdata = '0;
    {ext_sck, ext_din, slv} = '0;
    ext_sel = 1'b1;
    m_tx = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    mst(MODE_FULL, 1'b0, 8'h05, 8'ha5);
    mst(MODE_HALF, 1'b1, 8'h06, 8'h3c);
    t_fifo();
    t_slave(8'hc3, 8'h96);
    close_out();
  end
endmodule : tb
